// ===== rtl/pmoo_top.sv
// On/off, margin and fault-clear command registers behind a bus slave
// Assumes SCL/SDA and all pins are asynchronous; margin values come from core logic
//
// Contract
// RULE1: Slave address from strap pin, sixteen choices
// RULE2: Strap defaults loaded; bus overwrites after power-up
// RULE3: Operation command at 01h, reset 00h
// RULE4: Bus on bit acts only with command control
// RULE5: Soft-off bit always reads zero
// RULE6: Bits 5-2 select margin mode
// RULE7: Margin mode picks stored low/high target
// RULE8: Code 01 routes overcurrent warning to overheat
// RULE9: On/off configuration at 02h, reset 17h
// RULE10: Bits 7-5 read zero, bit 4 one
// RULE11: Bit 3 gates response to bus on bit
// RULE12: Bit 2 gates response to enable pin
// RULE13: Enable pin fixed active high
// RULE14: Turn-off is always immediate, no ramp
// RULE15: Clear-faults 03h clears status and alert
// RULE16: Persisting fault sets again; no restart
// RULE17: Host sends clear-faults without data bytes
// RULE18: Output on when every selected source agrees
`include "pmoo_consts.svh"
`timescale 1ns/100ps
module pmoo_top #(
    parameter int FAULT_W = 8,
    parameter int VOUT_W = 16,
    parameter logic [6:0] ADDR_BASE = 7'h40
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Management bus
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    output logic alert_output_n_o,
    // Straps
    input wire logic [`PMOO_STRAP_W-1:0] address_strap_pin_i,
    input wire logic strap_mode_i,
    input wire logic [7:0] strap_operation_i,
    input wire logic [7:0] strap_on_off_cfg_i,
    // Power stage pins
    input wire logic enable_pin_i,
    input wire logic iin_oc_warn_i,
    input wire logic [FAULT_W-1:0] fault_cond_i,
    // Stored output targets
    input wire logic [VOUT_W-1:0] vout_command_i,
    input wire logic [VOUT_W-1:0] vout_margin_low_i,
    input wire logic [VOUT_W-1:0] vout_margin_high_i,
    // Control outputs
    output logic output_enable_o,
    output logic fast_shutdown_o,
    output logic margin_low_o,
    output logic margin_high_o,
    output logic margin_act_on_fault_o,
    output logic [VOUT_W-1:0] vout_target_o,
    output logic regulator_overheat_output_o,
    output logic [FAULT_W-1:0] fault_status_o,
    output logic power_up_done_o
);
    localparam int SW = 2 + `PMOO_STRAP_W + 1 + 16 + 2 + FAULT_W;
    localparam logic [15:0] PWR_LAST = 16'(`PMOO_POWERUP_CYC - 1);
    localparam logic [7:0] OP_RST = `PMOO_OPERATION_RST;
    localparam logic [7:0] CFG_RST = `PMOO_ON_OFF_CFG_RST;

    // Synchronised pins
    logic [SW-1:0] sync_q;
    logic scl_s, sda_s, strap_mode_s, en_pin_s, iin_oc_s;
    logic [`PMOO_STRAP_W-1:0] strap_addr_s;
    logic [7:0] strap_op_s, strap_cfg_s;
    logic [FAULT_W-1:0] fault_s;

    pmoo_sync #(
        .W(SW)
    ) u_sync (
        .clk_i(ref_clk_i),
        .rst_i(rst_i),
        .d_i({scl_i, sda_i, address_strap_pin_i, strap_mode_i, strap_operation_i,
              strap_on_off_cfg_i, enable_pin_i, iin_oc_warn_i, fault_cond_i}),
        .q_o(sync_q)
    );

    assign {scl_s, sda_s, strap_addr_s, strap_mode_s, strap_op_s, strap_cfg_s,
            en_pin_s, iin_oc_s, fault_s} = sync_q;

    // Margin code decode
    function automatic pmoo_pkg::pmoo_margin_t margin_mode(input logic [3:0] code);
        unique case (code)
            `PMOO_MARGIN_LOW_IGNORE, `PMOO_MARGIN_LOW_ACT: margin_mode = pmoo_pkg::MRG_LOW;
            `PMOO_MARGIN_HIGH_IGNORE, `PMOO_MARGIN_HIGH_ACT: margin_mode = pmoo_pkg::MRG_HIGH;
            default: margin_mode = pmoo_pkg::MRG_OFF;
        endcase
    endfunction

    function automatic logic margin_acts(input logic [3:0] code);
        margin_acts = (code == `PMOO_MARGIN_LOW_ACT) || (code == `PMOO_MARGIN_HIGH_ACT);
    endfunction

    // Bus edge detection
    logic scl_d_ff, sda_d_ff;
    logic scl_rise, scl_fall, bus_start, bus_stop;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end else begin
            scl_d_ff <= scl_s;
            sda_d_ff <= sda_s;
        end
    end

    assign scl_rise = scl_s && !scl_d_ff;
    assign scl_fall = !scl_s && scl_d_ff;
    assign bus_start = scl_s && scl_d_ff && !sda_s && sda_d_ff;
    assign bus_stop = scl_s && scl_d_ff && sda_s && !sda_d_ff;

    // Register state
    logic op_on_ff, nxt_op_on;
    logic [3:0] op_margin_ff, nxt_op_margin;
    logic [1:0] op_alarm_ff, nxt_op_alarm;
    logic cfg_cmd_ff, nxt_cfg_cmd;
    logic cfg_pin_ff, nxt_cfg_pin;
    logic [6:0] slave_addr_ff, nxt_slave_addr;
    logic [15:0] pwr_cnt_ff, nxt_pwr_cnt;
    logic pwr_done_ff, nxt_pwr_done;
    logic [FAULT_W-1:0] fault_ff, nxt_fault;
    logic [7:0] rd_data;

    // Bus slave state
    pmoo_pkg::pmoo_state_t state_ff, nxt_state;
    logic [3:0] bit_cnt_ff, nxt_bit_cnt;
    logic [7:0] shift_ff, nxt_shift;
    logic [7:0] cmd_ff, nxt_cmd;
    logic [1:0] byte_idx_ff, nxt_byte_idx;
    logic rw_ff, nxt_rw;
    logic ack_ok_ff, nxt_ack_ok;
    logic sda_oe_n_ff, nxt_sda_oe_n;
    logic wr_stb, clr_stb;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    // Read data
    always_comb begin
        rd_data = 8'h00;
        unique case (cmd_ff)
            `PMOO_CMD_OPERATION: begin
                rd_data[`PMOO_OP_ON_BIT] = op_on_ff;
                rd_data[`PMOO_OP_SOFT_OFF_BIT] = 1'b0; // RULE5
                rd_data[`PMOO_OP_MARGIN_HI:`PMOO_OP_MARGIN_LO] = op_margin_ff;
                rd_data[`PMOO_OP_ALARM_HI:`PMOO_OP_ALARM_LO] = op_alarm_ff;
            end
            `PMOO_CMD_ON_OFF_CFG: begin
                rd_data[`PMOO_CFG_PWR_BIT] = 1'b1; // RULE10
                rd_data[`PMOO_CFG_CMD_BIT] = cfg_cmd_ff; // RULE11
                rd_data[`PMOO_CFG_PIN_BIT] = cfg_pin_ff; // RULE12
                rd_data[`PMOO_CFG_POL_BIT] = 1'b1; // RULE13
                rd_data[`PMOO_CFG_RATE_BIT] = 1'b1; // RULE14
            end
            default: rd_data = 8'h00;
        endcase
    end

    // Bus slave next state
    always_comb begin
        nxt_state = state_ff;
        nxt_bit_cnt = bit_cnt_ff;
        nxt_shift = shift_ff;
        nxt_cmd = cmd_ff;
        nxt_byte_idx = byte_idx_ff;
        nxt_rw = rw_ff;
        nxt_ack_ok = ack_ok_ff;
        nxt_sda_oe_n = sda_oe_n_ff;
        wr_stb = 1'b0;
        clr_stb = 1'b0;
        if (bus_start) begin
            nxt_state = pmoo_pkg::ST_ADDR;
            nxt_bit_cnt = 4'h0;
            nxt_byte_idx = 2'h0;
            nxt_sda_oe_n = 1'b1;
        end else if (bus_stop) begin
            nxt_state = pmoo_pkg::ST_IDLE;
            nxt_sda_oe_n = 1'b1;
            // Command code alone, no data byte
            clr_stb = !rw_ff && (byte_idx_ff == 2'h1) && (cmd_ff == `PMOO_CMD_FAULT_CLEAR); // RULE15 RULE17
        end else begin
            unique case (state_ff)
                pmoo_pkg::ST_IDLE: nxt_state = pmoo_pkg::ST_IDLE;
                pmoo_pkg::ST_ADDR, pmoo_pkg::ST_RX: begin
                    if (scl_rise && bit_cnt_ff != `PMOO_BYTE_BITS) begin
                        nxt_shift = {shift_ff[6:0], sda_s};
                        nxt_bit_cnt = bit_cnt_ff + 4'h1;
                    end else if (scl_fall && bit_cnt_ff == `PMOO_BYTE_BITS) begin
                        nxt_bit_cnt = 4'h0;
                        if (state_ff == pmoo_pkg::ST_RX) begin
                            nxt_state = pmoo_pkg::ST_ACK;
                            nxt_sda_oe_n = 1'b0;
                            if (byte_idx_ff == 2'h0) begin
                                nxt_cmd = shift_ff;
                            end else begin
                                wr_stb = 1'b1;
                            end
                            if (byte_idx_ff != 2'h3) begin
                                nxt_byte_idx = byte_idx_ff + 2'h1;
                            end
                        end else if (shift_ff[7:1] == slave_addr_ff && pwr_done_ff) begin // RULE1
                            nxt_state = pmoo_pkg::ST_ACK;
                            nxt_sda_oe_n = 1'b0;
                            nxt_rw = shift_ff[0];
                        end else begin
                            nxt_state = pmoo_pkg::ST_IDLE;
                        end
                    end
                end
                pmoo_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        if (rw_ff) begin
                            nxt_state = pmoo_pkg::ST_TX;
                            nxt_shift = rd_data;
                            nxt_sda_oe_n = rd_data[7];
                        end else begin
                            nxt_state = pmoo_pkg::ST_RX;
                            nxt_sda_oe_n = 1'b1;
                        end
                    end
                end
                pmoo_pkg::ST_TX: begin
                    if (scl_rise) begin
                        nxt_bit_cnt = bit_cnt_ff + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_cnt_ff == `PMOO_BYTE_BITS) begin
                            nxt_state = pmoo_pkg::ST_RACK;
                            nxt_bit_cnt = 4'h0;
                            nxt_sda_oe_n = 1'b1;
                        end else begin
                            nxt_shift = {shift_ff[6:0], 1'b0};
                            nxt_sda_oe_n = shift_ff[6];
                        end
                    end
                end
                pmoo_pkg::ST_RACK: begin
                    if (scl_rise) begin
                        nxt_ack_ok = !sda_s;
                    end else if (scl_fall) begin
                        if (ack_ok_ff) begin
                            nxt_state = pmoo_pkg::ST_TX;
                            nxt_shift = rd_data;
                            nxt_sda_oe_n = rd_data[7];
                        end else begin
                            nxt_state = pmoo_pkg::ST_IDLE;
                        end
                    end
                end
                default: begin
                    nxt_state = pmoo_pkg::ST_IDLE;
                    nxt_sda_oe_n = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_ff <= pmoo_pkg::ST_IDLE;
            bit_cnt_ff <= 4'h0;
            shift_ff <= 8'h00;
            cmd_ff <= 8'h00;
            byte_idx_ff <= 2'h0;
            rw_ff <= 1'b0;
            ack_ok_ff <= 1'b0;
            sda_oe_n_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            bit_cnt_ff <= nxt_bit_cnt;
            shift_ff <= nxt_shift;
            cmd_ff <= nxt_cmd;
            byte_idx_ff <= nxt_byte_idx;
            rw_ff <= nxt_rw;
            ack_ok_ff <= nxt_ack_ok;
            sda_oe_n_ff <= nxt_sda_oe_n;
        end
    end

    // Register next state
    always_comb begin
        nxt_op_on = op_on_ff;
        nxt_op_margin = op_margin_ff;
        nxt_op_alarm = op_alarm_ff;
        nxt_cfg_cmd = cfg_cmd_ff;
        nxt_cfg_pin = cfg_pin_ff;
        nxt_slave_addr = slave_addr_ff;
        nxt_pwr_cnt = pwr_cnt_ff;
        nxt_pwr_done = pwr_done_ff;
        if (!pwr_done_ff) begin
            nxt_pwr_cnt = pwr_cnt_ff + 16'h0001;
            if (pwr_cnt_ff == PWR_LAST) begin
                nxt_pwr_done = 1'b1;
                nxt_slave_addr = {ADDR_BASE[6:4], strap_addr_s}; // RULE1
                if (strap_mode_s) begin // RULE2
                    nxt_op_on = strap_op_s[`PMOO_OP_ON_BIT];
                    nxt_op_margin = strap_op_s[`PMOO_OP_MARGIN_HI:`PMOO_OP_MARGIN_LO];
                    nxt_op_alarm = strap_op_s[`PMOO_OP_ALARM_HI:`PMOO_OP_ALARM_LO];
                    nxt_cfg_cmd = strap_cfg_s[`PMOO_CFG_CMD_BIT];
                    nxt_cfg_pin = strap_cfg_s[`PMOO_CFG_PIN_BIT];
                end
            end
        end else if (wr_stb) begin // RULE2
            if (cmd_ff == `PMOO_CMD_OPERATION) begin // RULE3
                nxt_op_on = shift_ff[`PMOO_OP_ON_BIT];
                nxt_op_margin = shift_ff[`PMOO_OP_MARGIN_HI:`PMOO_OP_MARGIN_LO]; // RULE6
                nxt_op_alarm = shift_ff[`PMOO_OP_ALARM_HI:`PMOO_OP_ALARM_LO]; // RULE8
            end else if (cmd_ff == `PMOO_CMD_ON_OFF_CFG) begin // RULE9
                nxt_cfg_cmd = shift_ff[`PMOO_CFG_CMD_BIT]; // RULE11
                nxt_cfg_pin = shift_ff[`PMOO_CFG_PIN_BIT]; // RULE12
            end
        end
        // A fault seen in the clearing cycle survives
        nxt_fault = (clr_stb ? '0 : fault_ff) | fault_s; // RULE15 RULE16
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            op_on_ff <= OP_RST[`PMOO_OP_ON_BIT]; // RULE3
            op_margin_ff <= OP_RST[`PMOO_OP_MARGIN_HI:`PMOO_OP_MARGIN_LO];
            op_alarm_ff <= OP_RST[`PMOO_OP_ALARM_HI:`PMOO_OP_ALARM_LO];
            cfg_cmd_ff <= CFG_RST[`PMOO_CFG_CMD_BIT]; // RULE9
            cfg_pin_ff <= CFG_RST[`PMOO_CFG_PIN_BIT];
            slave_addr_ff <= 7'h00;
            pwr_cnt_ff <= 16'h0000;
            pwr_done_ff <= 1'b0;
            fault_ff <= '0;
        end else begin
            op_on_ff <= nxt_op_on;
            op_margin_ff <= nxt_op_margin;
            op_alarm_ff <= nxt_op_alarm;
            cfg_cmd_ff <= nxt_cfg_cmd;
            cfg_pin_ff <= nxt_cfg_pin;
            slave_addr_ff <= nxt_slave_addr;
            pwr_cnt_ff <= nxt_pwr_cnt;
            pwr_done_ff <= nxt_pwr_done;
            fault_ff <= nxt_fault;
        end
    end

    // Output control next state
    logic out_en_ff, nxt_out_en;
    logic mlow_ff, nxt_mlow, mhigh_ff, nxt_mhigh, mact_ff, nxt_mact;
    logic hot_ff, nxt_hot, alert_n_ff, nxt_alert_n;
    logic fs_ff, nxt_fs;
    logic [VOUT_W-1:0] target_ff, nxt_target;
    pmoo_pkg::pmoo_margin_t mode;

    always_comb begin
        mode = margin_mode(op_margin_ff); // RULE6
        // Faults do not gate the output, so clearing cannot restart it
        nxt_out_en = pwr_done_ff && (cfg_cmd_ff || cfg_pin_ff)
                     && (!cfg_cmd_ff || op_on_ff) && (!cfg_pin_ff || en_pin_s); // RULE4 RULE13 RULE18
        nxt_fs = !nxt_out_en; // RULE14
        nxt_mlow = mode == pmoo_pkg::MRG_LOW;
        nxt_mhigh = mode == pmoo_pkg::MRG_HIGH;
        nxt_mact = margin_acts(op_margin_ff);
        unique case (mode)
            pmoo_pkg::MRG_LOW: nxt_target = vout_margin_low_i; // RULE7
            pmoo_pkg::MRG_HIGH: nxt_target = vout_margin_high_i; // RULE7
            default: nxt_target = vout_command_i;
        endcase
        nxt_hot = (op_alarm_ff == `PMOO_ALARM_ON) && iin_oc_s; // RULE8
        nxt_alert_n = !(|nxt_fault); // RULE15 RULE16
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            out_en_ff <= 1'b0;
            fs_ff <= 1'b1;
            mlow_ff <= 1'b0;
            mhigh_ff <= 1'b0;
            mact_ff <= 1'b0;
            target_ff <= '0;
            hot_ff <= 1'b0;
            alert_n_ff <= 1'b1;
        end else begin
            out_en_ff <= nxt_out_en;
            fs_ff <= nxt_fs;
            mlow_ff <= nxt_mlow;
            mhigh_ff <= nxt_mhigh;
            mact_ff <= nxt_mact;
            target_ff <= nxt_target;
            hot_ff <= nxt_hot;
            alert_n_ff <= nxt_alert_n;
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe_n_o = sda_oe_n_ff;
    assign alert_output_n_o = alert_n_ff;
    assign output_enable_o = out_en_ff;
    assign fast_shutdown_o = fs_ff; // RULE14
    assign margin_low_o = mlow_ff;
    assign margin_high_o = mhigh_ff;
    assign margin_act_on_fault_o = mact_ff;
    assign vout_target_o = target_ff;
    assign regulator_overheat_output_o = hot_ff;
    assign fault_status_o = fault_ff;
    assign power_up_done_o = pwr_done_ff;

    // Checks
    property p_addr_strap;
        $rose(pwr_done_ff) |-> slave_addr_ff == {ADDR_BASE[6:4], $past(strap_addr_s)};
    endproperty
    a_addr_strap: assert property (p_addr_strap) else $error("slave address not from strap"); // RULE1

    property p_strap_default;
        $rose(pwr_done_ff) && $past(strap_mode_s) |-> op_margin_ff == $past(strap_op_s[5:2])
            && cfg_pin_ff == $past(strap_cfg_s[2]);
    endproperty
    a_strap_default: assert property (p_strap_default) else $error("strap defaults not loaded"); // RULE2

    property p_op_write;
        wr_stb && cmd_ff == `PMOO_CMD_OPERATION |=> op_on_ff == $past(shift_ff[7])
            && op_alarm_ff == $past(shift_ff[1:0]);
    endproperty
    a_op_write: assert property (p_op_write) else $error("operation write lost"); // RULE3

    property p_cmd_gate;
        output_enable_o |-> $past(!cfg_cmd_ff || op_on_ff) && $past(cfg_cmd_ff || cfg_pin_ff);
    endproperty
    a_cmd_gate: assert property (p_cmd_gate) else $error("output on without bus on bit"); // RULE4

    property p_soft_off_zero;
        cmd_ff == `PMOO_CMD_OPERATION |-> !rd_data[6];
    endproperty
    a_soft_off_zero: assert property (p_soft_off_zero) else $error("soft-off bit read as one"); // RULE5

    sequence s_low_held;
        op_margin_ff == `PMOO_MARGIN_LOW_IGNORE ##1 op_margin_ff == `PMOO_MARGIN_LOW_IGNORE;
    endsequence
    property p_margin_low;
        s_low_held |-> margin_low_o && !margin_high_o && !margin_act_on_fault_o;
    endproperty
    a_margin_low: assert property (p_margin_low) else $error("low margin not selected"); // RULE6

    property p_target;
        margin_high_o |-> vout_target_o == $past(vout_margin_high_i);
    endproperty
    a_target: assert property (p_target) else $error("high margin target wrong"); // RULE7

    property p_alarm;
        regulator_overheat_output_o |-> $past(op_alarm_ff == `PMOO_ALARM_ON && iin_oc_s);
    endproperty
    a_alarm: assert property (p_alarm) else $error("overheat without option"); // RULE8

    sequence s_quiet_clear;
        clr_stb && fault_s == '0;
    endsequence
    property p_clear;
        s_quiet_clear ##1 fault_s == '0 |-> fault_status_o == '0 ##1 alert_output_n_o;
    endproperty
    a_clear: assert property (p_clear) else $error("clear-faults left status set"); // RULE15

    property p_refault;
        clr_stb && fault_s != '0 |=> fault_status_o != '0 ##1 !alert_output_n_o;
    endproperty
    a_refault: assert property (p_refault) else $error("persisting fault lost on clear"); // RULE16

    property p_agree;
        pwr_done_ff && cfg_cmd_ff && op_on_ff && cfg_pin_ff && en_pin_s |=> output_enable_o;
    endproperty
    a_agree: assert property (p_agree) else $error("output off though sources agree"); // RULE18
endmodule

// ===== rtl/pmoo_consts.svh
// Constants of the on/off command register block
// Assumes a 250 MHz core clock and byte-wide command registers
`ifndef PMOO_CONSTS_SVH
`define PMOO_CONSTS_SVH

// Command codes
`define PMOO_CMD_OPERATION 8'h01
`define PMOO_CMD_ON_OFF_CFG 8'h02
`define PMOO_CMD_FAULT_CLEAR 8'h03

// Reset values
`define PMOO_OPERATION_RST 8'h00
`define PMOO_ON_OFF_CFG_RST 8'h17

// Operation field positions
`define PMOO_OP_ON_BIT 7
`define PMOO_OP_SOFT_OFF_BIT 6
`define PMOO_OP_MARGIN_HI 5
`define PMOO_OP_MARGIN_LO 2
`define PMOO_OP_ALARM_HI 1
`define PMOO_OP_ALARM_LO 0

// Configuration field positions
`define PMOO_CFG_PWR_BIT 4
`define PMOO_CFG_CMD_BIT 3
`define PMOO_CFG_PIN_BIT 2
`define PMOO_CFG_POL_BIT 1
`define PMOO_CFG_RATE_BIT 0

// Field codes
`define PMOO_ALARM_ON 2'h1
`define PMOO_MARGIN_OFF_PREFIX 2'h0
`define PMOO_MARGIN_LOW_IGNORE 4'h5
`define PMOO_MARGIN_LOW_ACT 4'h6
`define PMOO_MARGIN_HIGH_IGNORE 4'h9
`define PMOO_MARGIN_HIGH_ACT 4'ha

// Address and byte framing
`define PMOO_STRAP_W 4
`define PMOO_BYTE_BITS 4'h8

// Settle time before bus writes are accepted
`define PMOO_CLK_MHZ 250
`define PMOO_POWERUP_NS 1000
`define PMOO_POWERUP_CYC ((`PMOO_POWERUP_NS * `PMOO_CLK_MHZ + 999) / 1000)

`endif

// ===== rtl/pmoo_pkg.sv
// Types of the on/off command register block
// Assumes the constants header is included by the users
package pmoo_pkg;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_ADDR = 6'h02,
        ST_ACK = 6'h04,
        ST_RX = 6'h08,
        ST_TX = 6'h10,
        ST_RACK = 6'h20
    } pmoo_state_t;

    typedef enum logic [1:0] {
        MRG_OFF = 2'h0,
        MRG_LOW = 2'h1,
        MRG_HIGH = 2'h2
    } pmoo_margin_t;

endpackage

// ===== rtl/pmoo_sync.sv
// Two-stage synchroniser for a group of asynchronous levels
// Assumes inputs are quasi-static or bus-rate signals
`timescale 1ns/100ps
module pmoo_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Levels
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_ff <= '0;
            q_ff <= '0;
        end else begin
            meta_ff <= d_i;
            q_ff <= meta_ff;
        end
    end

    assign q_o = q_ff;
endmodule

// ===== testbench/pmoo_host.sv
// Behavioural bus host for the on/off command block
// Assumes open-drain SCL/SDA with pull-ups; 80 ns bus clock
`timescale 1ns/100ps
module pmoo_host (
    // Bus pins, 1 releases the line
    output logic scl_o,
    output logic sda_o,
    input wire logic sda_i
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // Start when st is high, stop otherwise; clock idles high
    task automatic cond(input logic st);
        sda_o = st;
        #20 scl_o = 1'b1;
        #20 sda_o = !st;
        #20 scl_o = !st;
        #20;
    endtask
    task automatic bit_x(input logic b, output logic r);
        sda_o = b;
        #20 scl_o = 1'b1;
        #20 r = sda_i;
        #20 scl_o = 1'b0;
        #20;
    endtask
    task automatic byte_x(input logic [7:0] d, output logic [7:0] q);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r);
            q[i] = r;
        end
    endtask
    // One frame; ack reports the address acknowledge
    task automatic xfer(input logic [6:0] a, input logic [7:0] c, input logic rd, input logic wd,
                        input logic [7:0] d, output logic [7:0] q, output logic ack);
        logic [7:0] t;
        logic r;
        cond(1'b1);
        byte_x({a, 1'b0}, t);
        bit_x(1'b1, r);
        ack = !r;
        byte_x(c, t);
        bit_x(1'b1, r);
        if (wd) begin
            byte_x(d, t);
            bit_x(1'b1, r);
        end
        if (rd) begin
            cond(1'b1);
            byte_x({a, 1'b1}, t);
            bit_x(1'b1, r);
            byte_x(8'hff, q);
            bit_x(1'b1, r);
        end
        cond(1'b0);
    endtask
endmodule

// ===== testbench/pmoo_top_test.sv
// Self-checking bench for the on/off command block
// Assumes the host model drives the bus; pull-ups on both lines
`timescale 1ns/100ps
module pmoo_top_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sm = 1'b0;
    logic [3:0] sa = 4'h0;
    logic [7:0] so = 8'h00;
    logic [7:0] sc = 8'h00;
    logic pin = 1'b0;
    logic iin = 1'b0;
    logic [7:0] fc = 8'h00;
    logic [15:0] vc = 16'h0;
    logic [15:0] vl = 16'h0;
    logic [15:0] vh = 16'h0;
    logic scl, h_sda, d_sda, d_oe_n, en, pud, fs, ml, mh, ma, oh, al_n;
    logic [15:0] tgt;
    logic [7:0] fst, q, op, cf;
    logic ack;
    logic [2:0] mg;
    int n_mismatch = 0;
    int cmp_count = 0;
    wire logic sda = h_sda & (d_oe_n | d_sda);
    wire logic [6:0] adr = {3'h4, sa};
    logic [3:0] mc [5] = '{4'h0, 4'h5, 4'h6, 4'h9, 4'ha};
    always #2 clk = ~clk;
    pmoo_host h (.scl_o(scl), .sda_o(h_sda), .sda_i(sda));
    pmoo_top dut_u (.ref_clk_i(clk), .rst_i(rst), .scl_i(scl), .sda_i(sda), .sda_o(d_sda),
        .sda_oe_n_o(d_oe_n), .alert_output_n_o(al_n), .address_strap_pin_i(sa), .strap_mode_i(sm),
        .strap_operation_i(so), .strap_on_off_cfg_i(sc), .enable_pin_i(pin), .iin_oc_warn_i(iin),
        .fault_cond_i(fc), .vout_command_i(vc), .vout_margin_low_i(vl), .vout_margin_high_i(vh),
        .output_enable_o(en), .fast_shutdown_o(fs), .margin_low_o(ml), .margin_high_o(mh),
        .margin_act_on_fault_o(ma), .vout_target_o(tgt), .regulator_overheat_output_o(oh),
        .fault_status_o(fst), .power_up_done_o(pud));
    function automatic logic en_f(logic [7:0] o, logic [7:0] c, logic p);
        return (c[3] | c[2]) & (!c[3] | o[7]) & (!c[2] | p);
    endfunction
    function automatic logic [2:0] mg_f(logic [3:0] m);
        return {m == 4'h5 || m == 4'h6, m == 4'h9 || m == 4'ha, m == 4'h6 || m == 4'ha};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic boot(input logic m);
        @(posedge clk) #1;
        rst = 1'b1;
        sm = m;
        sa = 4'($urandom());
        so = 8'($urandom());
        sc = 8'($urandom());
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        for (int i = 0; i < 300 && pud !== 1'b1; i++) @(posedge clk) #1;
        chk(16'(pud), 16'h1, "power-up");
        h.xfer(adr, 8'h01, 1'b1, 1'b0, 8'h00, q, ack);
        chk(16'(q), m ? 16'(so & 8'hbf) : 16'h0, "op reset");
        chk(16'(ack), 16'h1, "own address");
        h.xfer(adr, 8'h02, 1'b1, 1'b0, 8'h00, q, ack);
        chk(16'(q), m ? 16'({4'h1, sc[3:2], 2'h3}) : 16'h17, "cfg reset");
        h.xfer(adr ^ 7'h01, 8'h01, 1'b1, 1'b0, 8'h00, q, ack);
        chk(16'(ack), 16'h0, "foreign address");
        $display("boot mode %0d done", m);
    endtask
    initial begin
        void'($urandom(32'hccc1));
        vc = 16'($urandom());
        vl = 16'($urandom());
        vh = 16'($urandom());
        boot(1'b0);
        boot(1'b1);
        for (int i = 0; i < 12; i++) begin
            op = 8'($urandom());
            cf = 8'($urandom());
            if (i < 5)
                op[5:2] = mc[i];
            @(posedge clk) #1;
            pin = 1'($urandom());
            iin = 1'($urandom());
            h.xfer(adr, 8'h01, 1'b0, 1'b1, op, q, ack);
            h.xfer(adr, 8'h02, 1'b0, 1'b1, cf, q, ack);
            repeat (8) @(posedge clk);
            chk(16'(en), 16'(en_f(op, cf, pin)), "enable");
            chk(16'(fs), 16'(!en_f(op, cf, pin)), "shutdown");
            mg = mg_f(op[5:2]);
            chk(16'({ml, mh, ma}), 16'(mg), "margin");
            chk(tgt, mg[2] ? vl : mg[1] ? vh : vc, "target");
            chk(16'(oh), 16'(op[1:0] == 2'h1 && iin), "overheat");
            h.xfer(adr, 8'h01, 1'b1, 1'b0, 8'h00, q, ack);
            chk(16'(q), 16'(op & 8'hbf), "op read");
            h.xfer(adr, 8'h02, 1'b1, 1'b0, 8'h00, q, ack);
            chk(16'(q), 16'({4'h1, cf[3:2], 2'h3}), "cfg read");
        end
        $display("register test done");
        for (int k = 0; k < 2; k++) begin
            @(posedge clk) #1 fc = 8'($urandom()) | 8'h01;
            repeat (8) @(posedge clk);
            chk(16'(fst), 16'(fc), "fault set");
            chk(16'(al_n), 16'h0, "alert set");
            #1 fc = k ? 8'h01 : 8'h00;
            op = 8'(en);
            h.xfer(adr, 8'h03, 1'b0, 1'b0, 8'h00, q, ack);
            repeat (8) @(posedge clk);
            chk(16'(fst), 16'(fc), "fault clear");
            chk(16'(al_n), 16'(fc == 8'h00), "alert clear");
            chk(16'(en), 16'(op), "no restart");
        end
        $display("clear test done");
        print_verdict();
    end
    initial begin
        #300000;
        n_mismatch++;
        print_verdict();
    end
endmodule
